// >>> design/uf_engine.sv
// Purpose: Four-mode serial shift engine with AXI4-Lite registers.
// Assumes: aclk is the CPU clock; pin one input is asynchronous.
// Notes: Pin outputs are registered, so they trail internal state by one.
`timescale 1ns/100ps
`default_nettype none
module uf_engine import uf_pkg::*; (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [UF_AW-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [UF_AW-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Serial pins
  output logic port_one_bit_zero,
  input wire logic port_one_bit_one_level,
  output logic port_one_bit_one_drive,
  output logic port_one_bit_one_en
);

  function automatic logic mapped(input logic [UF_AW-1:0] a);
    mapped = (a == UF_OFS_CTRL) || (a == UF_OFS_BUF) ||
      (a == UF_OFS_BAUD) || (a == UF_OFS_STAT);
  endfunction : mapped

  uf_ctrl_t ctrl_q;
  uf_ctrl_t ctrl_d;
  logic [7:0] rx_buf_q;
  logic [7:0] reload_q;
  logic dbl_q;
  logic send_q;
  logic rx0_act_q;
  uf_rx_st_t rx_st_q;

  // Write channel
  logic aw_have_q;
  logic w_have_q;
  logic [UF_AW-1:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic wr_en;
  assign wr_en = aw_have_q && w_have_q && !bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      awready <= 1'b0;
      aw_addr_q <= '0;
    end else if (awvalid && awready) begin
      aw_have_q <= 1'b1;
      awready <= 1'b0;
      aw_addr_q <= awaddr;
    end else if (bvalid && bready) begin
      aw_have_q <= 1'b0;
    end else if (!aw_have_q) begin
      awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_q <= 1'b0;
      wready <= 1'b0;
      w_data_q <= '0;
      w_strb_q <= '0;
    end else if (wvalid && wready) begin
      w_have_q <= 1'b1;
      wready <= 1'b0;
      w_data_q <= wdata;
      w_strb_q <= wstrb;
    end else if (bvalid && bready) begin
      w_have_q <= 1'b0;
    end else if (!w_have_q) begin
      wready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= UF_RESP_OK;
    end else if (wr_en) begin
      bvalid <= 1'b1;
      bresp <= mapped(aw_addr_q) ? UF_RESP_OK : UF_RESP_ERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  logic wr_ctrl;
  logic wr_buf;
  logic wr_baud;
  assign wr_ctrl = wr_en && aw_addr_q == UF_OFS_CTRL && w_strb_q[0];
  assign wr_buf = wr_en && aw_addr_q == UF_OFS_BUF && w_strb_q[0];
  assign wr_baud = wr_en && aw_addr_q == UF_OFS_BAUD;

  // Read channel; reads have no side effects
  logic [31:0] rd_val;
  always_comb begin
    rd_val = '0;
    case (araddr)
      UF_OFS_CTRL: rd_val[7:0] = ctrl_q;
      UF_OFS_BUF: rd_val[7:0] = rx_buf_q;
      UF_OFS_BAUD: begin
        rd_val[UF_DBL_BIT] = dbl_q;
        rd_val[UF_RELOAD_LSB +: 8] = reload_q;
      end
      UF_OFS_STAT: begin
        rd_val[UF_STAT_TX_BIT] = send_q;
        rd_val[UF_STAT_RX_BIT] = rx0_act_q || rx_st_q != UF_RX_IDLE;
      end
      default: rd_val = '0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= UF_RESP_OK;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= rd_val;
      rresp <= mapped(araddr) ? UF_RESP_OK : UF_RESP_ERR;
    end else if (rvalid) begin
      if (rready) begin
        rvalid <= 1'b0;
      end
    end else begin
      arready <= 1'b1;
    end
  end

  // Baud setup
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dbl_q <= 1'b0;
      reload_q <= UF_RELOAD_RST;
    end else if (wr_baud) begin
      if (w_strb_q[0]) begin
        dbl_q <= w_data_q[UF_DBL_BIT];
      end
      if (w_strb_q[1]) begin
        reload_q <= w_data_q[UF_RELOAD_LSB +: 8];
      end
    end
  end

  // Machine cycle: six states of one clock each
  logic [2:0] st_q;
  logic mc;
  assign mc = st_q == UF_ST_LAST;
  always_ff @(posedge aclk) begin
    if (!aresetn || mc) begin
      st_q <= UF_ST_FIRST;
    end else begin
      st_q <= st_q + 3'h1;
    end
  end

  // Baud timer counts machine cycles; reload 0 gives 256
  logic [7:0] tmr_q;
  logic ovf;
  logic half_q;
  logic tick16;
  logic is_shift;
  assign is_shift = ctrl_q.mode == UF_M_SHIFT;
  assign ovf = mc && tmr_q == 8'h01;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tmr_q <= UF_RELOAD_RST;
    end else if (ovf) begin
      tmr_q <= reload_q;
    end else if (mc) begin
      tmr_q <= tmr_q - 8'h01;
    end
  end

  // Without the doubler every second event is dropped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      half_q <= 1'b0;
    end else if (ctrl_q.mode == UF_M_11FIX || ovf) begin
      half_q <= !half_q;
    end
  end

  always_comb begin
    case (ctrl_q.mode)
      UF_M_11FIX: tick16 = dbl_q || half_q;
      UF_M_10BIT,
      UF_M_11VAR: tick16 = ovf && (dbl_q || half_q);
      default: tick16 = 1'b0;
    endcase
  end

  // Transmit bit clock, free running
  logic [3:0] tx_div_q;
  logic troll;
  assign troll = tick16 && tx_div_q == UF_DIV_LAST;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_div_q <= '0;
    end else if (tick16) begin
      tx_div_q <= tx_div_q + 4'h1;
    end
  end

  // Pin one input: three stages, change taken once stages 2 and 3 agree
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic pin_q;
  logic prev_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
      pin_q <= 1'b1;
    end else begin
      s1_q <= port_one_bit_one_level;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        pin_q <= s3_q;
      end
    end
  end

  // Transmitter
  logic [8:0] tsr_q;
  uf_tx_st_t tx_st_q;
  logic tx_req_q;
  logic tx0_arm_q;
  logic tx0_fin_q;
  logic tx_first_q;
  logic tx_last;
  logic ti_set;
  logic fill;
  // Before the first shift the ninth bit is not yet backed by the stop one
  assign tx_last = tsr_q[8:1] == UF_TX_LAST && !tx_first_q;
  assign fill = tx_first_q && ctrl_q.mode[1];
  assign ti_set = is_shift ? (st_q == UF_ST_FIRST && tx0_fin_q)
    : (troll && tx_st_q == UF_TX_DATA && tx_last);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tsr_q <= '0;
      tx_st_q <= UF_TX_IDLE;
      tx_req_q <= 1'b0;
      tx0_arm_q <= 1'b0;
      tx0_fin_q <= 1'b0;
      tx_first_q <= 1'b0;
      send_q <= 1'b0;
    end else if (wr_buf) begin
      // Ninth position: marker in mode 0, one in 10-bit, chosen bit else
      tsr_q <= {ctrl_q.mode[1] ? ctrl_q.tx_ninth : 1'b1,
        w_data_q[7:0]};
      tx_req_q <= 1'b1;
    end else if (is_shift) begin
      if (mc && tx_req_q) begin
        tx_req_q <= 1'b0;
        tx0_arm_q <= 1'b1;
      end else if (mc && tx0_arm_q) begin
        tx0_arm_q <= 1'b0;
        send_q <= 1'b1;
      end else if (mc && send_q && !tx0_fin_q) begin
        tsr_q <= {1'b0, tsr_q[8:1]};
        tx0_fin_q <= tx_last;
      end else if (ti_set) begin
        send_q <= 1'b0;
        tx0_fin_q <= 1'b0;
      end
    end else if (troll) begin
      case (tx_st_q)
        UF_TX_IDLE: begin
          if (tx_req_q) begin
            tx_req_q <= 1'b0;
            send_q <= 1'b1;
            tx_st_q <= UF_TX_START;
          end
        end
        UF_TX_START: begin
          tx_first_q <= 1'b1;
          tx_st_q <= UF_TX_DATA;
        end
        UF_TX_DATA: begin
          tsr_q <= {fill, tsr_q[8:1]};
          tx_first_q <= 1'b0;
          if (tx_last) begin
            send_q <= 1'b0;
            tx_st_q <= UF_TX_IDLE;
          end
        end
        default: tx_st_q <= UF_TX_IDLE;
      endcase
    end
  end

  // Receiver, both shift mode and async modes
  logic [8:0] rsr_q;
  logic [3:0] rx_div_q;
  logic rx0_arm_q;
  logic rx0_fin_q;
  logic rx0_smp_q;
  logic rx_first_q;
  logic [1:0] vote_q;
  logic vote;
  logic edge_seen;
  logic rx0_go;
  logic decide;
  logic final_bit;
  logic accept;
  logic ri_set;
  assign rx0_go = is_shift && ctrl_q.rx_en && !ctrl_q.rx_flag &&
    !rx0_arm_q && !rx0_act_q && !send_q && !tx_req_q &&
    !tx0_arm_q;
  assign vote = (vote_q[0] && vote_q[1]) || (vote_q[0] && pin_q) ||
    (vote_q[1] && pin_q);
  assign edge_seen = tick16 && prev_q && !pin_q;
  assign decide = rx_st_q == UF_RX_BITS && tick16 &&
    rx_div_q == UF_VOTE_C;
  assign final_bit = decide && !rx_first_q && !rsr_q[0];
  // Stop bit in 10-bit mode, ninth bit otherwise
  assign accept = !ctrl_q.rx_flag &&
    (!ctrl_q.filter || vote);
  assign ri_set = is_shift ? (st_q == UF_ST_FIRST && rx0_fin_q)
    : (final_bit && accept);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_q <= 1'b1;
    end else if (tick16) begin
      prev_q <= pin_q;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rsr_q <= '0;
      rx_buf_q <= '0;
      rx_div_q <= '0;
      rx0_arm_q <= 1'b0;
      rx0_act_q <= 1'b0;
      rx0_fin_q <= 1'b0;
      rx0_smp_q <= 1'b0;
      rx_first_q <= 1'b0;
      vote_q <= '0;
      rx_st_q <= UF_RX_IDLE;
    end else if (is_shift) begin
      rx_st_q <= UF_RX_IDLE;
      if (rx0_go) begin
        rx0_arm_q <= 1'b1;
      end else if (mc && rx0_arm_q) begin
        rx0_arm_q <= 1'b0;
        rx0_act_q <= 1'b1;
        rsr_q <= {1'b1, UF_RX0_PRESET};
      end else if (st_q == UF_ST_SAMPLE && rx0_act_q) begin
        rx0_smp_q <= pin_q;
      end else if (mc && rx0_act_q && !rx0_fin_q) begin
        rsr_q[7:0] <= {rsr_q[6:0], rx0_smp_q};
        if (!rsr_q[7]) begin
          rx0_fin_q <= 1'b1;
          // Left shifts put the first bit on top; reverse for LSB first
          rx_buf_q <= {rx0_smp_q, rsr_q[0], rsr_q[1], rsr_q[2], rsr_q[3],
            rsr_q[4], rsr_q[5], rsr_q[6]};
        end
      end else if (ri_set) begin
        rx0_act_q <= 1'b0;
        rx0_fin_q <= 1'b0;
      end
    end else begin
      rx0_arm_q <= 1'b0;
      rx0_act_q <= 1'b0;
      rx0_fin_q <= 1'b0;
      case (rx_st_q)
        UF_RX_IDLE: begin
          if (ctrl_q.rx_en && edge_seen) begin
            rx_div_q <= '0;
            rsr_q <= UF_RX_PRESET;
            rx_first_q <= 1'b1;
            rx_st_q <= UF_RX_BITS;
          end
        end
        UF_RX_BITS: begin
          if (tick16) begin
            rx_div_q <= rx_div_q + 4'h1;
            if (rx_div_q == UF_VOTE_A) begin
              vote_q[0] <= pin_q;
            end
            if (rx_div_q == UF_VOTE_B) begin
              vote_q[1] <= pin_q;
            end
          end
          if (decide) begin
            rx_first_q <= 1'b0;
            rsr_q <= {vote, rsr_q[8:1]};
            if (rx_first_q && vote) begin
              rx_st_q <= UF_RX_IDLE;
            end else if (final_bit) begin
              if (accept) begin
                rx_buf_q <= rsr_q[8:1];
              end
              // Eleven-bit frames wait out the stop bit
              rx_st_q <= ctrl_q.mode[1] ? UF_RX_HOLD
                : UF_RX_IDLE;
            end
          end
        end
        UF_RX_HOLD: begin
          if (tick16) begin
            rx_div_q <= rx_div_q + 4'h1;
          end
          if (decide || (tick16 && rx_div_q == UF_VOTE_C)) begin
            rx_st_q <= UF_RX_IDLE;
          end
        end
        default: rx_st_q <= UF_RX_IDLE;
      endcase
    end
  end

  // Control register; hardware set beats a software clear
  always_comb begin
    ctrl_d = ctrl_q;
    if (wr_ctrl) begin
      ctrl_d = uf_ctrl_t'(w_data_q[7:0]);
    end
    if (ti_set) begin
      ctrl_d.tx_flag = 1'b1;
    end
    if (ri_set) begin
      ctrl_d.rx_flag = 1'b1;
    end
    if (ri_set && !is_shift) begin
      ctrl_d.rx_ninth = vote;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= uf_ctrl_t'(UF_CTRL_RST);
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // Pins; shift clock low in S3..S5 of each active machine cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_one_bit_zero <= 1'b1;
      port_one_bit_one_drive <= 1'b1;
      port_one_bit_one_en <= 1'b0;
    end else if (is_shift) begin
      port_one_bit_zero <= !((send_q || rx0_act_q) &&
        st_q >= UF_ST_LO_FIRST && st_q < UF_ST_LAST);
      port_one_bit_one_drive <= tsr_q[0];
      port_one_bit_one_en <= send_q;
    end else begin
      port_one_bit_zero <= !send_q ? 1'b1
        : (tx_st_q == UF_TX_START ? 1'b0 : tsr_q[0]);
      port_one_bit_one_drive <= 1'b1;
      port_one_bit_one_en <= 1'b0;
    end
  end

endmodule : uf_engine
`default_nettype wire

// >>> design/uf_pkg.sv
// Purpose: Constants, types and register map of the serial shift engine.
// Assumes: 32-bit AXI4-Lite, one machine cycle is six aclk cycles.
// Notes: Contract list below.
//
// Contract
// - Shift mode: data on pin one, clock on pin zero, LSB first, clk/6.
// - Shift mode buffer write loads marker one; sending starts a cycle later.
// - Shift clock low in states 3-5, high 6,1,2; shift right, zeros in.
// - Marker next to MSB: last shift, stop sending, set transmit flag.
// - Shift receive starts on enable and clear flag; preload 11111110.
// - Shift receive samples pin at S5P2, shifts left once per cycle.
// - Preload zero at left end: last shift, load buffer, set receive flag.
// - Ten-bit frame: start, 8 data LSB first, stop; stop kept as ninth.
// - Async buffer write loads ninth bit; start follows next 16-rollover.
// - Start bit first, data path one bit later, first shift one later.
// - Ten-bit mode ends and sets transmit flag at tenth rollover.
// - Eleven-bit frames carry programmable ninth bit; mode 2 fixed rate.
// - Eleven-bit: first shift inserts stop one; ends at eleventh rollover.
// - Falling edge at 16x rate resets counter and presets 1FF.
// - Each bit sampled at counter states 7, 8, 9; majority wins.
// - Start bit not zero: drop and hunt for a new falling edge.
// - Ten-bit accept needs flag clear and filter off or stop one.
// - Eleven-bit accept needs flag clear and filter off or ninth one.
// - Eleven-bit receiver rearms one bit time after the final shift.
// - Filter ignored in shift mode; in ten-bit mode it checks the stop.
// - Mode 2 rate is clk/32, or clk/16 with the doubler set.
// - Modes 1 and 3 run from the baud timer overflow and doubler.
package uf_pkg;
  localparam int UF_AW = 4;
  localparam logic [3:0] UF_OFS_CTRL = 4'h0;
  localparam logic [3:0] UF_OFS_BUF = 4'h4;
  localparam logic [3:0] UF_OFS_BAUD = 4'h8;
  localparam logic [3:0] UF_OFS_STAT = 4'hC;
  localparam logic [1:0] UF_RESP_OK = 2'h0;
  localparam logic [1:0] UF_RESP_ERR = 2'h2;
  localparam int UF_DBL_BIT = 0;
  localparam int UF_RELOAD_LSB = 8;
  localparam int UF_STAT_TX_BIT = 0;
  localparam int UF_STAT_RX_BIT = 1;
  localparam logic [7:0] UF_CTRL_RST = 8'h00;
  localparam logic [7:0] UF_RELOAD_RST = 8'h01;
  // Machine cycle states S1..S6 are 0..5
  localparam logic [2:0] UF_ST_FIRST = 3'h0;
  localparam logic [2:0] UF_ST_LO_FIRST = 3'h2;
  localparam logic [2:0] UF_ST_SAMPLE = 3'h4;
  localparam logic [2:0] UF_ST_LAST = 3'h5;
  localparam logic [3:0] UF_DIV_LAST = 4'hF;
  localparam logic [3:0] UF_VOTE_A = 4'h7;
  localparam logic [3:0] UF_VOTE_B = 4'h8;
  localparam logic [3:0] UF_VOTE_C = 4'h9;
  localparam logic [8:0] UF_RX_PRESET = 9'h1FF;
  localparam logic [7:0] UF_RX0_PRESET = 8'hFE;
  localparam logic [7:0] UF_TX_LAST = 8'h01;
  typedef enum logic [1:0] {
    UF_M_SHIFT = 2'b00,
    UF_M_10BIT = 2'b01,
    UF_M_11FIX = 2'b10,
    UF_M_11VAR = 2'b11
  } uf_mode_t;
  typedef struct packed {
    uf_mode_t mode;
    logic filter;
    logic rx_en;
    logic tx_ninth;
    logic rx_ninth;
    logic tx_flag;
    logic rx_flag;
  } uf_ctrl_t;
  typedef enum logic [1:0] {
    UF_TX_IDLE = 2'b00,
    UF_TX_START = 2'b01,
    UF_TX_DATA = 2'b10
  } uf_tx_st_t;
  typedef enum logic [1:0] {
    UF_RX_IDLE = 2'b00,
    UF_RX_BITS = 2'b01,
    UF_RX_HOLD = 2'b10
  } uf_rx_st_t;
endpackage : uf_pkg

// >>> dv/uf_engine_chk_sva.sv
// Purpose: Port assertions for the serial shift engine.
// Assumes: Pins registered; a machine cycle is six aclk.
// Notes: Bound into every uf_engine.
`timescale 1ns/100ps
`default_nettype none
module uf_engine_chk import uf_pkg::*; (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bus handshakes
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic [UF_AW-1:0] araddr,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic [1:0] rresp,
  input wire logic [31:0] rdata,
  // Serial pins
  input wire logic port_one_bit_zero,
  input wire logic port_one_bit_one_drive,
  input wire logic port_one_bit_one_en
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [3:0] lows_q;
  logic ar_bad_q;
  // Low phases of the shift clock within one send
  always_ff @(posedge aclk) begin
    if (!aresetn || !port_one_bit_one_en) begin
      lows_q <= 4'h0;
    end else if ($fell(port_one_bit_zero)) begin
      lows_q <= lows_q + 4'h1;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ar_bad_q <= 1'b0;
    end else if (arvalid && arready) begin
      ar_bad_q <= (araddr[1:0] != 2'b00);
    end
  end
  clk_low_a:
    assert property (port_one_bit_one_en && $fell(port_one_bit_zero)
      |-> ##1 !port_one_bit_zero ##1 !port_one_bit_zero
      ##1 port_one_bit_zero)
    else $error("shift clock low phase wrong");
  data_hold_a:
    assert property (port_one_bit_one_en && !port_one_bit_zero
      && !$past(port_one_bit_zero) |-> $stable(port_one_bit_one_drive))
    else $error("shift data moved while clock low");
  bit_count_a:
    assert property ($fell(port_one_bit_one_en) |-> lows_q == 4'h8)
    else $error("shift send did not give eight clocks");
  idle_high_a:
    assert property ($fell(port_one_bit_one_en) |-> port_one_bit_zero)
    else $error("shift clock not high at end of send");
  low_min_a:
    assert property ($fell(port_one_bit_zero) |-> ##2 !port_one_bit_zero)
    else $error("low phase on pin zero too short");
  rd_resp_a:
    assert property (arvalid && arready |=> rvalid
      && rresp == (ar_bad_q ? UF_RESP_ERR : UF_RESP_OK)
      && (!ar_bad_q || rdata == 32'h0))
    else $error("read answer wrong");
  wr_resp_a:
    assert property (awvalid && awready && wvalid && wready
      |-> ##[1:3] bvalid)
    else $error("write answer late");
  wr_busy_a:
    assert property (bvalid |-> !awready && !wready)
    else $error("write ready while answer pending");
endmodule : uf_engine_chk
bind uf_engine uf_engine_chk chk_u (.aclk, .aresetn, .awvalid, .awready,
  .wvalid, .wready, .bvalid, .araddr, .arvalid, .arready, .rvalid, .rresp,
  .rdata, .port_one_bit_zero, .port_one_bit_one_drive, .port_one_bit_one_en);
`default_nettype wire

// >>> dv/uf_remote.sv
// Purpose: Remote serial node driving the engine receive pin.
// Assumes: Line has a pull-up, so released means high.
// Notes: Behavioural; one frame per go pulse.
`timescale 1ns/100ps
`default_nettype none
module uf_remote (
  // Clocks
  input wire logic aclk,
  input wire logic shift_clk,
  // Frame request
  input wire logic go,
  input wire logic sync_mode,
  input wire logic [10:0] frame,
  input wire logic [7:0] nb,
  input wire logic [7:0] per,
  // Line to the engine
  output var logic line
);
  initial line = 1'b1;
  always @(posedge aclk) begin
    if (go) begin
      if (sync_mode) begin
        // First bit stands before the clock; later bits follow each rise,
        // so the engine's input stages settle before the late sample
        line <= frame[0];
        for (int i = 1; i < 8; i++) begin
          @(posedge shift_clk);
          line <= frame[i];
        end
        @(posedge shift_clk);
        line <= 1'b1;
      end else begin
        for (int i = 0; i < nb; i++) begin
          line <= frame[i];
          repeat (per) @(posedge aclk);
        end
        line <= 1'b1;
      end
    end
  end
endmodule : uf_remote
`default_nettype wire

// >>> dv/test_uart_four_mode_shift_engine.sv
// Purpose: Self-checking bench for the four-mode serial engine.
// Assumes: Reload 1 with doubler gives 96 aclk per async bit.
// Notes: Mode 2 bit is 16 or 32 aclk by doubler.
`timescale 1ns/100ps
`default_nettype none
module test_uart_four_mode_shift_engine import uf_pkg::*; ;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [UF_AW-1:0] awaddr = 4'h0;
  logic [UF_AW-1:0] araddr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, p0, drv, en, line, e9;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, d;
  logic [10:0] b;
  logic [10:0] frm = 11'h0;
  logic [7:0] kept = 8'h00;
  logic go = 1'b0, sm = 1'b0;
  logic [7:0] nb = 8'h0, per = 8'h0;
  wire logic level;
  int err_count = 0, n_tests = 0, cyc = 0;
  logic [31:0] seed = 32'h47FCF13F;
  logic [1:0] tm [4] = '{2'h1, 2'h2, 2'h2, 2'h3};
  logic td [4] = '{1'b1, 1'b1, 1'b0, 1'b1};
  int tp [4] = '{96, 16, 32, 96};
  // Mode, filter, rx_en, ninth, stop, clear, accept
  logic [7:0] rc [8] = '{8'h57, 8'h72, 8'h77, 8'hF6, 8'hFF, 8'hDC, 8'hD7,
    8'h46};
  assign level = en ? drv : line;
  always #25 aclk = ~aclk;
  uf_engine dut_u (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
    .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .port_one_bit_zero(p0),
    .port_one_bit_one_level(level), .port_one_bit_one_drive(drv),
    .port_one_bit_one_en(en));
  uf_remote rem_u (.aclk, .shift_clk(p0), .go, .sync_mode(sm), .frame(frm),
    .nb, .per, .line);
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction : xs
  function automatic logic [10:0] fr(input logic [7:0] v, input logic n9,
    input logic st, input logic m1);
    return m1 ? {1'b0, st, v, 1'b0} : {st, n9, v, 1'b0};
  endfunction : fr
  task automatic give_verdict;
    if (err_count == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while ((awvalid && !awready) || (wvalid && !wready));
    while (!bvalid) @(posedge aclk);
    r = bresp;
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rd
  // Mid-bit samples of the transmit pin
  task automatic cap(input int n, input int p);
    b = 11'h0;
    @(negedge p0);
    repeat (p / 2) @(negedge aclk);
    for (int i = 0; i < n; i++) begin
      b[i] = p0;
      repeat (p) @(negedge aclk);
    end
  endtask : cap
  task automatic m0cap;
    b = 11'h0;
    for (int i = 0; i < 8; i++) begin
      @(negedge p0);
      @(negedge aclk);
      b[i] = drv;
    end
  endtask : m0cap
  task automatic send(input logic [10:0] f, input logic [7:0] n,
    input logic [7:0] p, input logic s);
    @(posedge aclk);
    frm <= f;
    nb <= n;
    per <= p;
    sm <= s;
    go <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
  endtask : send
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_count++;
      give_verdict();
    end
  end
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd(UF_OFS_CTRL);
    chk(d, {24'h0, UF_CTRL_RST});
    rd(UF_OFS_BAUD);
    chk(d, {16'h0, UF_RELOAD_RST, 8'h00});
    wr(UF_OFS_STAT, 32'h3);
    rd(UF_OFS_STAT);
    chk(d, 32'h0);
    wr(4'h1, 32'hFF);
    chk({30'h0, r}, {30'h0, UF_RESP_ERR});
    rd(4'h2);
    chk({30'h0, r}, {30'h0, UF_RESP_ERR});
    rd(UF_OFS_CTRL);
    chk(d, 32'h0);
    for (int k = 0; k < 4; k++) begin
      seed = xs(seed);
      wr(UF_OFS_BAUD, {16'h0, 8'h01, 7'h0, td[k]});
      wr(UF_OFS_CTRL, {24'h0, tm[k], 2'b00, seed[8], 3'b000});
      fork
        wr(UF_OFS_BUF, {24'h0, seed[7:0]});
        cap((tm[k] == 2'h1) ? 10 : 11, tp[k]);
      join
      chk({21'h0, b}, {21'h0, fr(seed[7:0], seed[8], 1'b1,
        tm[k] == 2'h1)});
      rd(UF_OFS_CTRL);
      chk(d & 32'h2, 32'h2);
    end
    seed = xs(seed);
    wr(UF_OFS_CTRL, 32'h0);
    fork
      wr(UF_OFS_BUF, {24'h0, seed[7:0]});
      m0cap();
    join
    chk({21'h0, b}, {24'h0, seed[7:0]});
    repeat (12) @(posedge aclk);
    rd(UF_OFS_CTRL);
    chk(d & 32'h2, 32'h2);
    wr(UF_OFS_BAUD, 32'h101);
    wr(UF_OFS_CTRL, 32'h50);
    send(11'h0, 8'h1, 8'h20, 1'b0);
    repeat (300) @(posedge aclk);
    rd(UF_OFS_CTRL);
    chk(d & 32'h1, 32'h0);
    foreach (rc[j]) begin
      seed = xs(seed);
      if (rc[j][1]) wr(UF_OFS_CTRL, {24'h0, rc[j][7:4], 4'h0});
      send(fr(seed[7:0], rc[j][3], rc[j][2], rc[j][7:6] == 2'h1),
        (rc[j][7:6] == 2'h1) ? 8'hA : 8'hB, 8'h60, 1'b0);
      repeat (1300) @(posedge aclk);
      e9 = (rc[j][7:6] == 2'h1) ? rc[j][2] : rc[j][3];
      rd(UF_OFS_CTRL);
      chk(d & 32'h1, {31'h0, rc[j][0] | !rc[j][1]});
      if (rc[j][0]) begin
        chk(d & 32'h4, {29'h0, e9, 2'b00});
        kept = seed[7:0];
      end
      // Refused frames, flag held, filtered or receiver off, leave the buffer alone
      rd(UF_OFS_BUF);
      chk(d, {24'h0, kept});
    end
    seed = xs(seed);
    send({3'h0, seed[7:0]}, 8'h8, 8'h60, 1'b1);
    wr(UF_OFS_CTRL, 32'h30);
    repeat (120) @(posedge aclk);
    rd(UF_OFS_CTRL);
    chk(d & 32'h1, 32'h1);
    rd(UF_OFS_BUF);
    chk(d, {24'h0, seed[7:0]});
    give_verdict();
  end
endmodule : test_uart_four_mode_shift_engine
`default_nettype wire
